// ==== design/hip_consts.vh ====
// Constants for the homing and interpolated position mode logic
`ifndef HIP_CONSTS_VH
`define HIP_CONSTS_VH
// ----------------------------------------
// Register word addresses
// ----------------------------------------
`define HIP_A_CTRL 4'h0
`define HIP_A_MODE 4'h1
`define HIP_A_METHOD 4'h2
`define HIP_A_STATUS 4'h3
`define HIP_A_TARGET 4'h4
`define HIP_A_POS 4'h5
`define HIP_A_CURLVL 4'h6
`define HIP_A_BLKMS 4'h7
`define HIP_A_IPMS 4'h8
`define HIP_A_BUFCFG 4'h9
`define HIP_A_VLIM 4'ha
`define HIP_A_FEWIN 4'hb
`define HIP_A_FEMS 4'hc
`define HIP_A_DECODE 4'hd
// ----------------------------------------
// Field positions
// ----------------------------------------
`define HIP_CW_START 4
`define HIP_CW_HALT 8
`define HIP_SW_TGT 10
`define HIP_SW_ACT 12
`define HIP_SW_ERR 13
// ----------------------------------------
// Mode and method codes
// ----------------------------------------
`define HIP_MODE_HOME 8'h06
`define HIP_MODE_IP 8'h07
`define HIP_M_CURPOS 8'h23
// ----------------------------------------
// Timing
// ----------------------------------------
`define HIP_CLK_MHZ 100
`define HIP_MS_NS 1000000
`define HIP_MS_CYC (`HIP_MS_NS * `HIP_CLK_MHZ / 1000)
`endif

// ==== design/hip_mode_logic.v ====
// Homing method decode, homing sequencer and interpolated position mode logic
//
// Register access over Avalon-MM and the address map were left to the implementer.
`timescale 1ns/1ps
`include "hip_consts.vh"
// ----------------------------------------
// Top module
// ----------------------------------------
module hip_mode_logic (
  // Clock and reset
  input wire clk,
  input wire rstn,
  // Avalon-MM slave
  input wire [3:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  output reg [31:0] avs_readdata,
  output wire avs_waitrequest,
  // Drive state
  input wire closed_loop,
  input wire op_enabled,
  input wire [15:0] motor_current,
  input wire [31:0] actual_pos,
  // Switches and index, asynchronous pins
  input wire lim_neg_pin,
  input wire lim_pos_pin,
  input wire home_sw_pin,
  input wire index_pin,
  // Motion outputs
  output reg [31:0] demand_pos,
  output reg [31:0] speed_limit,
  output reg motor_drive,
  output reg drive_dir_pos,
  output reg homing_done,
  output reg interpolation_running_flag
);
  // ----------------------------------------
  // Registers
  // ----------------------------------------
  reg [15:0] ctrl_reg;
  reg [7:0] mode_reg;
  reg [7:0] method_reg;
  reg [31:0] target_reg;
  reg [15:0] curlvl_reg;
  reg [15:0] blkms_reg;
  reg [15:0] ipms_reg;
  reg bufcfg_reg;
  reg [31:0] vprof_reg;
  reg [31:0] vmotor_reg;
  reg [31:0] fewin_reg;
  reg [15:0] fems_reg;
  reg ack_reg;
  reg tgt_wr_reg;
  // One wait cycle per access
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_reg;
  wire acc = (avs_read | avs_write) & ack_reg;
  // ----------------------------------------
  // Method decode
  // ----------------------------------------
  wire neg_m = method_reg[7];
  wire [7:0] mag = neg_m ? (~method_reg + 8'h01) : method_reg;
  wire in_a = (mag >= 8'h01) && (mag <= 8'h0e);
  wire in_b = (mag >= 8'h11) && (mag <= 8'h1e);
  wire [7:0] base = in_b ? (mag - 8'h10) : mag;
  wire use_index = in_a || (!neg_m && (mag == 8'h21 || mag == 8'h22));
  wire blk_ok = (base == 8'h01 || base == 8'h02 || (base >= 8'h07 && base <= 8'h0e))
    && (in_a || in_b);
  wire idx_only = !neg_m && (mag == 8'h21 || mag == 8'h22);
  wire cur_pos = !neg_m && (mag == `HIP_M_CURPOS);
  wire valid_m = neg_m ? blk_ok : ((in_a || in_b) || idx_only || cur_pos);
  // Reference kind: ref_lim for limit (bases 1, 2), ref_home for home edge (bases 3 to 6)
  wire ref_lim = (base == 8'h01 || base == 8'h02);
  wire ref_home = (base >= 8'h03 && base <= 8'h06);
  wire left_edge = (base == 8'h03 || base == 8'h04);
  wire pos_side = (base == 8'h02) || (base >= 8'h07 && base <= 8'h0a);
  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  reg [3:0] s1, s2, s3, pin_q;
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s1 <= 4'h0;
      s2 <= 4'h0;
      s3 <= 4'h0;
      pin_q <= 4'h0;
    end else begin
      s1 <= {index_pin, home_sw_pin, lim_pos_pin, lim_neg_pin};
      s2 <= s1;
      s3 <= s2;
      pin_q <= (pin_q & ~(s2 ^ s3)) | (s2 & s3);
    end
  end
  reg [3:0] pin_d;
  always @(posedge clk or negedge rstn) begin
    if (!rstn)
      pin_d <= 4'h0;
    else
      pin_d <= pin_q;
  end
  wire l_neg = pin_q[0];
  wire l_pos = pin_q[1];
  wire h_rise = pin_q[2] & ~pin_d[2];
  wire h_fall = ~pin_q[2] & pin_d[2];
  wire idx_rise = pin_q[3] & ~pin_d[3];
  // ----------------------------------------
  // Millisecond tick
  // ----------------------------------------
  reg [19:0] ms_cnt;
  wire ms_tick = (ms_cnt == `HIP_MS_CYC - 1);
  always @(posedge clk or negedge rstn) begin
    if (!rstn)
      ms_cnt <= 20'h0;
    else
      ms_cnt <= ms_tick ? 20'h0 : ms_cnt + 20'h1;
  end
  // ----------------------------------------
  // Homing sequencer
  // ----------------------------------------
  localparam H_IDLE = 3'd0, H_SEEK = 3'd1, H_PUSH = 3'd2, H_INDEX = 3'd3,
    H_DONE = 3'd4, H_ERR = 3'd5;
  reg [2:0] h_state;
  reg [15:0] h_cnt;
  reg homed_once;
  wire home_mode = (mode_reg == `HIP_MODE_HOME);
  wire start = ctrl_reg[`HIP_CW_START];
  wire hit_lim = pos_side ? l_pos : l_neg;
  wire hit_blk = motor_current > curlvl_reg;
  wire hit_edge = left_edge ? (drive_dir_pos ? h_rise : h_fall)
    : (drive_dir_pos ? h_fall : h_rise);
  wire seek_hit = neg_m ? hit_blk : (ref_home ? hit_edge : hit_lim);
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      h_state <= H_IDLE;
      h_cnt <= 16'h0;
      homed_once <= 1'b0;
      drive_dir_pos <= 1'b0;
      homing_done <= 1'b0;
    end else begin
      homing_done <= 1'b0;
      case (h_state)
        H_IDLE: begin
          if (home_mode && start) begin
            if (!valid_m || (neg_m && !closed_loop)) begin
              h_state <= H_ERR;
              homed_once <= 1'b0;
            end else if (cur_pos) begin
              h_state <= H_DONE;
              homed_once <= 1'b1;
              homing_done <= 1'b1;
            end else if (!op_enabled) begin
              h_state <= H_ERR;
              homed_once <= 1'b0;
            end else begin
              homed_once <= 1'b0;
              drive_dir_pos <= pos_side;
              h_state <= idx_only ? H_INDEX : H_SEEK;
            end
          end
        end
        H_SEEK: begin
          if (!start || !home_mode)
            h_state <= H_IDLE;
          else if (seek_hit) begin
            h_cnt <= 16'h0;
            if (neg_m)
              h_state <= H_PUSH;
            else if (use_index)
              h_state <= H_INDEX;
            else begin
              h_state <= H_DONE;
              homed_once <= 1'b1;
              homing_done <= 1'b1;
            end
          end
        end
        H_PUSH: begin
          if (!start || !home_mode)
            h_state <= H_IDLE;
          else if (h_cnt >= blkms_reg) begin
            drive_dir_pos <= ~drive_dir_pos;
            if (use_index)
              h_state <= H_INDEX;
            else begin
              h_state <= H_DONE;
              homed_once <= 1'b1;
              homing_done <= 1'b1;
            end
          end else if (ms_tick)
            h_cnt <= h_cnt + 16'h1;
        end
        H_INDEX: begin
          if (!start || !home_mode)
            h_state <= H_IDLE;
          else if (idx_rise) begin
            h_state <= H_DONE;
            homed_once <= 1'b1;
            homing_done <= 1'b1;
          end
        end
        H_DONE, H_ERR: begin
          if (!start)
            h_state <= H_IDLE;
        end
        default: h_state <= H_IDLE;
      endcase
    end
  end
  wire h_run = (h_state == H_SEEK) || (h_state == H_PUSH) || (h_state == H_INDEX);
  reg [2:0] h_code;
  always @* begin
    case (h_state)
      H_SEEK, H_PUSH, H_INDEX: h_code = 3'b000;
      H_DONE: h_code = 3'b011;
      H_ERR: h_code = 3'b101;
      default: h_code = homed_once ? 3'b010 : 3'b001;
    endcase
  end
  // ----------------------------------------
  // Interpolated position mode
  // ----------------------------------------
  wire ip_mode = (mode_reg == `HIP_MODE_IP);
  wire ip_act = ip_mode && ctrl_reg[`HIP_CW_START] && op_enabled;
  wire halt = ctrl_reg[`HIP_CW_HALT];
  wire [31:0] vlim = (vprof_reg < vmotor_reg) ? vprof_reg : vmotor_reg;
  reg [31:0] step_reg;
  reg [15:0] ip_ms;
  reg [15:0] fe_cnt;
  reg fe_flag;
  reg halt_last;
  wire [31:0] diff = target_reg - demand_pos;
  wire dneg = diff[31];
  wire [31:0] dmag = dneg ? (~diff + 32'h1) : diff;
  wire [31:0] fe = actual_pos - demand_pos;
  wire [31:0] femag = fe[31] ? (~fe + 32'h1) : fe;
  wire [31:0] stp = (step_reg > dmag) ? dmag : step_reg;
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      demand_pos <= 32'h0;
      step_reg <= 32'h0;
      ip_ms <= 16'h0;
      fe_cnt <= 16'h0;
      fe_flag <= 1'b0;
      halt_last <= 1'b0;
      interpolation_running_flag <= 1'b0;
      speed_limit <= 32'h0;
      motor_drive <= 1'b0;
    end else begin
      interpolation_running_flag <= ip_act;
      halt_last <= halt;
      speed_limit <= closed_loop ? vlim : vprof_reg;
      motor_drive <= h_run || (ip_act && !halt);
      if (!ip_act)
        demand_pos <= actual_pos;
      else begin
        if (tgt_wr_reg) begin
          // Step per ms spreads the move over the interval
          step_reg <= (ipms_reg == 16'h0) ? dmag : (dmag / {16'h0, ipms_reg});
          ip_ms <= 16'h0;
        end else if (ms_tick && !halt) begin
          demand_pos <= dneg ? demand_pos - stp : demand_pos + stp;
          ip_ms <= ip_ms + 16'h1;
        end
      end
      if (!(ip_act && closed_loop) || femag <= fewin_reg) begin
        fe_cnt <= 16'h0;
        fe_flag <= 1'b0;
      end else if (fe_cnt > fems_reg)
        fe_flag <= 1'b1;
      else if (ms_tick)
        fe_cnt <= fe_cnt + 16'h1;
    end
  end
  wire reached = halt_last ? (actual_pos == demand_pos) : (target_reg == actual_pos);
  wire [2:0] ip_code = {fe_flag, interpolation_running_flag, reached};
  wire [2:0] sc = home_mode ? h_code : (ip_mode ? ip_code : 3'b000);
  wire [15:0] status = {2'b00, sc[2], sc[1], 1'b0, sc[0], 10'h0};
  // ----------------------------------------
  // Register access
  // ----------------------------------------
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ack_reg <= 1'b0;
      tgt_wr_reg <= 1'b0;
      ctrl_reg <= 16'h0;
      mode_reg <= 8'h0;
      method_reg <= 8'h0;
      target_reg <= 32'h0;
      curlvl_reg <= 16'h0;
      blkms_reg <= 16'h0;
      ipms_reg <= 16'h1;
      bufcfg_reg <= 1'b0;
      vprof_reg <= 32'h0;
      vmotor_reg <= 32'h0;
      fewin_reg <= 32'h0;
      fems_reg <= 16'h0;
      avs_readdata <= 32'h0;
    end else begin
      ack_reg <= (avs_read | avs_write) & ~ack_reg;
      tgt_wr_reg <= 1'b0;
      if (avs_read & ~ack_reg) begin
        case (avs_address)
          `HIP_A_CTRL: avs_readdata <= {16'h0, ctrl_reg};
          `HIP_A_MODE: avs_readdata <= {24'h0, mode_reg};
          `HIP_A_METHOD: avs_readdata <= {24'h0, method_reg};
          `HIP_A_STATUS: avs_readdata <= {16'h0, status};
          `HIP_A_TARGET: avs_readdata <= target_reg;
          `HIP_A_POS: avs_readdata <= demand_pos;
          `HIP_A_CURLVL: avs_readdata <= {16'h0, curlvl_reg};
          `HIP_A_BLKMS: avs_readdata <= {16'h0, blkms_reg};
          `HIP_A_IPMS: avs_readdata <= {16'h0, ipms_reg};
          `HIP_A_BUFCFG: avs_readdata <= {31'h0, bufcfg_reg};
          `HIP_A_VLIM: avs_readdata <= vprof_reg;
          `HIP_A_FEWIN: avs_readdata <= fewin_reg;
          `HIP_A_FEMS: avs_readdata <= {16'h0, fems_reg};
          `HIP_A_DECODE: avs_readdata <= {24'h0, valid_m, use_index, neg_m, ref_lim,
            ref_home, pos_side, idx_only, cur_pos};
          default: avs_readdata <= 32'h0;
        endcase
      end
      if (avs_write && acc) begin
        case (avs_address)
          `HIP_A_CTRL: ctrl_reg <= avs_writedata[15:0];
          `HIP_A_MODE: mode_reg <= avs_writedata[7:0];
          `HIP_A_METHOD: method_reg <= avs_writedata[7:0];
          `HIP_A_TARGET: begin
            if (bufcfg_reg) begin
              target_reg <= avs_writedata;
              tgt_wr_reg <= 1'b1;
            end
          end
          `HIP_A_CURLVL: curlvl_reg <= avs_writedata[15:0];
          `HIP_A_BLKMS: blkms_reg <= avs_writedata[15:0];
          `HIP_A_IPMS: ipms_reg <= avs_writedata[15:0];
          `HIP_A_BUFCFG: bufcfg_reg <= avs_writedata[0];
          `HIP_A_VLIM: vprof_reg <= avs_writedata;
          `HIP_A_FEWIN: fewin_reg <= avs_writedata;
          `HIP_A_FEMS: fems_reg <= avs_writedata[15:0];
          `HIP_A_DECODE: vmotor_reg <= avs_writedata;
          default: ;
        endcase
      end
    end
  end
endmodule // hip_mode_logic

// ==== sim/hip_mode_sva.sv ====
// Assertion checker for the homing and interpolated position logic
`timescale 1ns/1ps
module hip_mode_sva (
  // Clock and reset
  input wire clk,
  input wire rstn,
  // Register bus
  input wire [3:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_readdata,
  input wire avs_waitrequest,
  // Drive state
  input wire op_enabled,
  // Motion
  input wire motor_drive,
  input wire homing_done,
  input wire interpolation_running_flag
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  wire req = avs_read | avs_write;
  a_req_first_wait: assert property ($rose(req) |-> avs_waitrequest)
    else $error("no wait in first request cycle");
  a_ack_one_cycle: assert property (req && avs_waitrequest |=> !avs_waitrequest)
    else $error("request not answered after one cycle");
  a_read_hold: assert property (!avs_read |=> $stable(avs_readdata))
    else $error("read data changed without a read");
  a_unmapped_zero: assert property (avs_read && avs_waitrequest && avs_address >= 4'he
    |=> avs_readdata == 32'h0) else $error("unmapped read not zero");
  a_done_pulse: assert property (homing_done |=> !homing_done)
    else $error("homing done longer than one cycle");
  a_ip_needs_op: assert property (interpolation_running_flag |-> $past(op_enabled))
    else $error("interpolation without operation enabled");
  a_ip_drops: assert property (!op_enabled |=> !interpolation_running_flag)
    else $error("interpolation flag stays without operation enabled");
  a_done_not_ip: assert property (homing_done |-> !interpolation_running_flag)
    else $error("homing done while interpolating");
  c_homing_done: cover property (homing_done);
  c_ip_active: cover property (interpolation_running_flag && motor_drive);
  c_read_ack: cover property (avs_read && !avs_waitrequest);
endmodule // hip_mode_sva

bind hip_mode_logic hip_mode_sva u_sva (
  .clk(clk),
  .rstn(rstn),
  .avs_address(avs_address),
  .avs_read(avs_read),
  .avs_write(avs_write),
  .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest),
  .op_enabled(op_enabled),
  .motor_drive(motor_drive),
  .homing_done(homing_done),
  .interpolation_running_flag(interpolation_running_flag)
);

// ==== sim/hip_host_model.sv ====
// Host controller model: Avalon-MM master that writes and reads the mode registers
`timescale 1ns/1ps
module hip_host_model (
  // Clock
  input wire clk,
  // Avalon-MM master
  output reg [3:0] avs_address,
  output reg avs_read,
  output reg avs_write,
  output reg [31:0] avs_writedata,
  input wire [31:0] avs_readdata,
  input wire avs_waitrequest,
  // Hang flag
  output reg hung
);
  initial begin
    avs_address = 4'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    hung = 1'b0;
  end
  // Holds the request until waitrequest is seen low at a rising edge, for at most 20 edges
  task xfer(input bit rd, input [3:0] a, input [31:0] d, output [31:0] q);
    integer n;
    reg w;
    begin
      n = 0;
      w = 1'b1;
      q = 32'h0;
      @(posedge clk);
      avs_address <= a;
      avs_read <= rd;
      avs_write <= !rd;
      avs_writedata <= d;
      while (w && n < 20) begin
        @(posedge clk);
        w = avs_waitrequest;
        q = avs_readdata;
        n = n + 1;
      end
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      if (w !== 1'b0) hung <= 1'b1;
    end
  endtask
endmodule // hip_host_model

// ==== sim/tb.sv ====
// Self-checking testbench for the homing and interpolated position logic
`timescale 1ns/1ps
module tb;
  reg clk, rstn, closed_loop, op_enabled;
  reg lim_neg_pin, lim_pos_pin, home_sw_pin, index_pin;
  reg [15:0] motor_current;
  reg [31:0] actual_pos, q;
  reg [71:0] rows [0:16];
  reg [11:0] homes [0:4];
  wire [3:0] avs_address;
  wire avs_read, avs_write, avs_waitrequest, hung;
  wire [31:0] avs_writedata, avs_readdata, demand_pos, speed_limit;
  wire motor_drive, drive_dir_pos, homing_done, interpolation_running_flag;
  integer num_errors, checked, i, n;
  // ----------------------------------------
  // Design, host model and clock
  // ----------------------------------------
  hip_mode_logic dut (.clk(clk), .rstn(rstn), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .closed_loop(closed_loop), .op_enabled(op_enabled),
    .motor_current(motor_current), .actual_pos(actual_pos), .lim_neg_pin(lim_neg_pin),
    .lim_pos_pin(lim_pos_pin), .home_sw_pin(home_sw_pin), .index_pin(index_pin),
    .demand_pos(demand_pos), .speed_limit(speed_limit), .motor_drive(motor_drive),
    .drive_dir_pos(drive_dir_pos), .homing_done(homing_done),
    .interpolation_running_flag(interpolation_running_flag));
  hip_host_model host (.clk(clk), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .hung(hung));
  always #5 clk = ~clk;
  always @(posedge hung) begin
    num_errors = num_errors + 1;
    complete_run;
  end
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task check(input [31:0] seen, input [31:0] exp, input string name);
    begin
      checked = checked + 1;
      if (seen !== exp) begin
        num_errors = num_errors + 1;
        $display("mismatch %0s expected %h seen %h", name, exp, seen);
      end
    end
  endtask
  task wr(input [3:0] a, input [31:0] d);
    host.xfer(1'b0, a, d, q);
  endtask
  task rd(input [3:0] a);
    host.xfer(1'b1, a, 32'h0, q);
  endtask
  task settle(input integer k);
    begin
      repeat (k) @(posedge clk);
      #1;
    end
  endtask
  task home_start(input [7:0] m);
    begin
      wr(4'h0, 32'h0);
      wr(4'h2, {24'h0, m});
      wr(4'h0, 32'h10);
    end
  endtask
  task home_try(input [7:0] m, input op, input cl, input [31:0] st);
    begin
      op_enabled <= op;
      closed_loop <= cl;
      home_start(m);
      settle(20);
      rd(4'h3);
      check(q & 32'h3400, st, "homing status");
    end
  endtask
  task complete_run;
    begin
      $display("checks %0d errors %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
    end
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    clk = 0; rstn = 0; closed_loop = 1; op_enabled = 0; motor_current = 16'h0;
    actual_pos = 32'h1000; lim_neg_pin = 0; lim_pos_pin = 0; home_sw_pin = 0; index_pin = 0;
    num_errors = 0; checked = 0;
    // Write addr, data, read addr, expected, mask
    rows[0] = {4'h6, 32'h40, 4'h6, 16'h40, 16'hffff};
    rows[1] = {4'h7, 32'h0, 4'h7, 16'h0, 16'hffff};
    rows[2] = {4'ha, 32'h1f4, 4'ha, 16'h1f4, 16'hffff};
    rows[3] = {4'hb, 32'h5, 4'hb, 16'h5, 16'hffff};
    rows[4] = {4'he, 32'h55, 4'he, 16'h0, 16'hffff};
    rows[5] = {4'h2, 32'h01, 4'hd, 16'hc0, 16'he3};
    rows[6] = {4'h2, 32'h0e, 4'hd, 16'hc0, 16'he3};
    rows[7] = {4'h2, 32'h11, 4'hd, 16'h80, 16'he3};
    rows[8] = {4'h2, 32'h1e, 4'hd, 16'h80, 16'he3};
    rows[9] = {4'h2, 32'h21, 4'hd, 16'hc2, 16'he3};
    rows[10] = {4'h2, 32'h23, 4'hd, 16'h81, 16'he3};
    rows[11] = {4'h2, 32'hff, 4'hd, 16'he0, 16'he3}; // Negated method
    rows[12] = {4'h2, 32'hf2, 4'hd, 16'he0, 16'he3};
    rows[13] = {4'h2, 32'hef, 4'hd, 16'ha0, 16'he3};
    rows[14] = {4'h2, 32'he2, 4'hd, 16'ha0, 16'he3};
    rows[15] = {4'h2, 32'hfd, 4'hd, 16'h0, 16'h80};
    rows[16] = {4'h2, 32'h0f, 4'hd, 16'h0, 16'h80};
    // Direction (2 = any), stimulus, method
    homes[0] = {2'd0, 2'd0, 8'h11};
    homes[1] = {2'd1, 2'd1, 8'h12};
    homes[2] = {2'd0, 2'd2, 8'hef};
    homes[3] = {2'd2, 2'd3, 8'h21};
    homes[4] = {2'd2, 2'd3, 8'h15};
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    rd(4'h8);
    check(q, 32'h1, "interval reset");
    check({motor_drive, homing_done, interpolation_running_flag}, 32'h0, "outputs reset");
    wr(4'h1, {24'h0, `HIP_MODE_HOME});
    rd(4'h3);
    check(q & 32'h3400, 32'h0400, "idle status");
    for (i = 0; i < 17; i = i + 1) begin
      wr(rows[i][71:68], rows[i][67:36]);
      rd(rows[i][35:32]);
      check(q[15:0] & rows[i][15:0], rows[i][31:16], "register row");
    end
    op_enabled <= 1'b1;
    for (i = 0; i < 5; i = i + 1) begin
      home_start(homes[i][7:0]);
      settle(8);
      check(motor_drive, 32'h1, "homing drive");
      if (homes[i][11:10] != 2'd2) check(drive_dir_pos, homes[i][11:10], "direction");
      @(posedge clk);
      case (homes[i][9:8])
        2'd0: lim_neg_pin <= 1'b1;
        2'd1: lim_pos_pin <= 1'b1;
        2'd2: motor_current <= 16'h80;
        default: {index_pin, home_sw_pin} <= 2'b11;
      endcase
      n = 0;
      while (homing_done !== 1'b1 && n < 300) begin
        settle(1);
        n = n + 1;
      end
      check(n < 300, 32'h1, "homing finish");
      @(posedge clk);
      {lim_neg_pin, lim_pos_pin, home_sw_pin, index_pin} <= 4'h0;
      motor_current <= 16'h0;
      settle(2);
      rd(4'h3);
      check(q & 32'h3400, 32'h1400, "homing status");
    end
    home_start(8'h11);
    wr(4'h0, 32'h0);
    rd(4'h3);
    check(q & 32'h3400, 32'h0400, "aborted status");
    home_try(8'h01, 1'b0, 1'b1, 32'h2400);
    home_try(8'hff, 1'b1, 1'b0, 32'h2400);
    home_try(8'h0f, 1'b1, 1'b1, 32'h2400);
    home_try(`HIP_M_CURPOS, 1'b0, 1'b0, 32'h1400);
    wr(4'h0, 32'h0);
    op_enabled <= 1'b1;
    closed_loop <= 1'b1;
    wr(4'h1, {24'h0, `HIP_MODE_IP});
    wr(4'h9, 32'h0);
    wr(4'h4, 32'h2000);
    wr(4'h0, 32'h10);
    settle(4);
    check(interpolation_running_flag, 32'h1, "ip flag");
    check(demand_pos, actual_pos, "refused target");
    rd(4'h4);
    check(q, 32'h0, "refused target register");
    wr(4'h9, 32'h1);
    wr(4'h4, 32'h2000);
    rd(4'h4);
    check(q, 32'h2000, "accepted target");
    rd(4'h5);
    check(q, 32'h1000, "demand at start");
    rd(4'h3);
    check(q & 32'h1000, 32'h1000, "ip status");
    wr(4'h0, 32'h110);
    settle(4);
    check(motor_drive, 32'h0, "halt stop");
    rd(4'h3);
    check(q & 32'h0400, 32'h0400, "halt reached");
    wr(4'h0, 32'h10);
    settle(4);
    check(motor_drive, 32'h1, "halt release");
    rd(4'h3);
    check(q & 32'h0400, 32'h0, "target not reached");
    wr(4'hd, 32'h12c);
    settle(4);
    check(speed_limit, 32'h12c, "closed limit");
    @(posedge clk);
    closed_loop <= 1'b0;
    settle(4);
    check(speed_limit, 32'h1f4, "open limit");
    @(posedge clk);
    op_enabled <= 1'b0;
    settle(3);
    check(interpolation_running_flag, 32'h0, "ip off");
    // Second reset in mid-run
    @(posedge clk);
    rstn <= 1'b0;
    settle(2);
    check({motor_drive, homing_done, interpolation_running_flag}, 32'h0, "outputs in reset");
    check(speed_limit | demand_pos, 32'h0, "motion in reset");
    @(posedge clk);
    rstn <= 1'b1;
    rd(4'h1);
    check(q, 32'h0, "mode after reset");
    rd(4'h8);
    check(q, 32'h1, "interval after reset");
    complete_run;
  end
endmodule // tb
